// [src/mas_top.sv]
// converter sequencer, averaging, warnings and alert with a wishbone register file
`timescale 1ns/1ns
module mas_top
  import mas_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // converter front end and serial engine
  input  wire logic [15:0] shunt_sample,
  input  wire logic [15:0] bus_sample,
  input  wire logic        comm_fault,
  // open-drain alert pin
  input  wire logic        alert_in,
  output logic             alert_out,
  output logic             alert_oe
);
  mas_conv_if cv();
  mas_conv_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (.sys_clk(sys_clk), .srst(srst), .cv(cv));

  mas_state_type state_reg, state_next;
  logic [11:0] setup_reg;
  logic [6:0]  mask_reg;
  logic [15:0] oc_lim_reg, op_lim_reg, uv_lim_reg, ov_lim_reg;
  logic [3:0]  warn_reg;
  logic        comm_reg, ovf_reg, ready_reg, asleep_reg, alert_reg, ack_reg;
  logic [31:0] dat_reg;
  logic [15:0] sh_reg, bu_reg, cu_reg, pw_reg;
  logic [15:0] res_sh_reg, res_bu_reg, res_cu_reg, res_pw_reg;
  logic [26:0] acc_sh_reg, acc_bu_reg, acc_cu_reg, acc_pw_reg;
  logic [10:0] cnt_reg;
  logic [9:0]  wake_reg;
  logic        start_reg;

  // bus decode
  wire        req      = wb_cyc_i && wb_stb_i;
  wire        acc_edge = req && ack_reg;
  wire        wr       = acc_edge && wb_we_i && (&wb_sel_i[1:0]);
  wire        rd       = acc_edge && !wb_we_i;
  wire        wr_setup = wr && (wb_adr_i == ADR_SETUP);
  wire [2:0]  new_mode = wb_dat_i[MODE_LSB +: 3];
  wire        new_pd   = (new_mode[1:0] == 2'b00);
  wire        wr_act   = wr_setup && !new_pd;
  wire        rd_mask  = rd && (wb_adr_i == ADR_MASK);
  wire        wr_vstat = wr && (wb_adr_i == ADR_VSTAT);
  wire        wr_comm  = wr && (wb_adr_i == ADR_COMM);
  wire        wr_warn  = wr && (wb_adr_i == ADR_WARN);

  // mode and setup fields
  wire [2:0]  mode   = setup_reg[MODE_LSB +: 3];
  wire        do_sh  = mode[0];
  wire        do_bu  = mode[1];
  wire        cont   = mode[2];
  wire        pd     = (mode[1:0] == 2'b00);
  wire [3:0]  shamt  = mas_avg_shift(setup_reg[AVG_LSB +: 3]);
  wire [10:0] avg_n  = 11'(1 << shamt);
  wire        cnt_last = (cnt_reg + 11'h1 == avg_n);

  // measurement arithmetic
  wire signed [31:0] prod   = $signed(cu_reg) * $signed(bus_sample);
  wire        sh_fs  = (shunt_sample == FS_POS) || (shunt_sample == FS_NEG);
  wire        bu_fs  = (bus_sample == FS_POS) || (bus_sample == FS_NEG);
  wire        sh_done = (state_reg == ST_SHUNT) && cv.done && !start_reg;
  wire        bu_done = (state_reg == ST_BUS) && cv.done && !start_reg;
  wire        ovf_evt = (sh_done && sh_fs) || (bu_done && bu_fs);
  wire [15:0] avg_sh = 16'($signed(acc_sh_reg) >>> shamt);
  wire [15:0] avg_bu = 16'($signed(acc_bu_reg) >>> shamt);
  wire [15:0] avg_cu = 16'($signed(acc_cu_reg) >>> shamt);
  wire [15:0] avg_pw = 16'($signed(acc_pw_reg) >>> shamt);
  wire [3:0]  warn_hit;
  assign warn_hit[SRC_OC] = $signed(avg_cu[15:4]) > $signed(oc_lim_reg[15:4]);
  assign warn_hit[SRC_OP] = $signed(avg_pw[15:4]) > $signed(op_lim_reg[15:4]);
  assign warn_hit[SRC_UV] = $signed(avg_bu[15:4]) < $signed(uv_lim_reg[15:4]);
  assign warn_hit[SRC_OV] = $signed(avg_bu[15:4]) > $signed(ov_lim_reg[15:4]);
  wire        upd      = (state_reg == ST_UPDATE);
  wire [3:0]  warn_set = upd ? warn_hit : 4'h0;
  wire [6:0]  src_vec  = {ready_reg, ovf_reg, comm_reg, warn_reg};
  wire        alert_next = |(src_vec & mask_reg);

  // sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:   state_next = ST_IDLE;
      ST_WAKE:   state_next = (wake_reg == 10'(RECOVER_CYCLES - 1)) ? ST_LAUNCH : ST_WAKE;
      ST_LAUNCH: state_next = do_sh ? ST_SHUNT : ST_BUS;
      ST_SHUNT:  state_next = !sh_done ? ST_SHUNT : (do_bu ? ST_BUS : ST_ACC);
      ST_BUS:    state_next = bu_done ? ST_ACC : ST_BUS;
      ST_ACC:    state_next = cnt_last ? ST_UPDATE : ST_LAUNCH;
      ST_UPDATE: state_next = cont ? ST_LAUNCH : ST_IDLE;
    endcase
    if (wr_setup) begin
      state_next = new_pd ? ST_IDLE : ((asleep_reg || state_reg == ST_WAKE) ? ST_WAKE : ST_LAUNCH);
    end
  end
  wire start_next = (state_next == ST_SHUNT || state_next == ST_BUS)
                    && (state_reg != state_next || wr_setup);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg  <= ST_LAUNCH;
      start_reg  <= 1'b0;
      asleep_reg <= 1'b0;
      wake_reg   <= 10'h000;
    end else begin
      state_reg  <= state_next;
      start_reg  <= start_next;
      asleep_reg <= wr_setup ? new_pd : asleep_reg;
      wake_reg   <= (state_reg == ST_WAKE && !wr_setup) ? wake_reg + 10'h001 : 10'h000;
    end
  end
  assign cv.start   = start_reg;
  assign cv.ct_code = (state_reg == ST_BUS) ? setup_reg[BCT_LSB +: 3] : setup_reg[SCT_LSB +: 3];

  // samples, current and power
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sh_reg <= 16'h0000;
      bu_reg <= 16'h0000;
      cu_reg <= 16'h0000;
      pw_reg <= 16'h0000;
    end else if (sh_done) begin
      sh_reg <= shunt_sample;
      cu_reg <= shunt_sample;
    end else if (bu_done) begin
      bu_reg <= bus_sample;
      pw_reg <= prod[30:15];
    end
  end

  // accumulators and averaged outputs
  always_ff @(posedge sys_clk) begin
    if (srst || wr_setup || upd) begin
      acc_sh_reg <= 27'h0;
      acc_bu_reg <= 27'h0;
      acc_cu_reg <= 27'h0;
      acc_pw_reg <= 27'h0;
      cnt_reg    <= 11'h000;
    end else if (state_reg == ST_ACC) begin
      acc_sh_reg <= acc_sh_reg + 27'($signed(sh_reg));
      acc_bu_reg <= acc_bu_reg + 27'($signed(bu_reg));
      acc_cu_reg <= acc_cu_reg + 27'($signed(cu_reg));
      acc_pw_reg <= acc_pw_reg + 27'($signed(pw_reg));
      cnt_reg    <= cnt_last ? cnt_reg : cnt_reg + 11'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      res_sh_reg <= 16'h0000;
      res_bu_reg <= 16'h0000;
      res_cu_reg <= 16'h0000;
      res_pw_reg <= 16'h0000;
    end else if (upd) begin
      res_sh_reg <= avg_sh;
      res_bu_reg <= avg_bu;
      res_cu_reg <= avg_cu;
      res_pw_reg <= avg_pw;
    end
  end

  // software registers and sticky flags, set wins over clear
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      setup_reg  <= SETUP_RST;
      mask_reg   <= MASK_RST;
      oc_lim_reg <= HI_LIM_RST;
      op_lim_reg <= HI_LIM_RST;
      uv_lim_reg <= LO_LIM_RST;
      ov_lim_reg <= HI_LIM_RST;
      warn_reg   <= 4'h0;
      comm_reg   <= 1'b0;
      ovf_reg    <= 1'b0;
      ready_reg  <= 1'b0;
    end else begin
      if (wr_setup) setup_reg <= wb_dat_i[11:0];
      if (wr && wb_adr_i == ADR_MASK) mask_reg <= wb_dat_i[6:0];
      if (wr && wb_adr_i == ADR_OC_LIM) oc_lim_reg <= wb_dat_i[15:0];
      if (wr && wb_adr_i == ADR_OP_LIM) op_lim_reg <= wb_dat_i[15:0];
      if (wr && wb_adr_i == ADR_UV_LIM) uv_lim_reg <= wb_dat_i[15:0];
      if (wr && wb_adr_i == ADR_OV_LIM) ov_lim_reg <= wb_dat_i[15:0];
      warn_reg  <= warn_set | (warn_reg & ~(wr_warn ? wb_dat_i[3:0] : 4'h0));
      comm_reg  <= comm_fault | (comm_reg & !(wr_comm && wb_dat_i[0]));
      ovf_reg   <= ovf_evt | (ovf_reg & !(wr_vstat && wb_dat_i[1]));
      ready_reg <= upd | (ready_reg & !(wr_act || rd_mask));
    end
  end

  // read mux
  wire [31:0] rd_data =
    (wb_adr_i == ADR_SETUP)  ? {20'h0, setup_reg} :
    (wb_adr_i == ADR_MASK)   ? {25'h0, mask_reg} :
    (wb_adr_i == ADR_VSTAT)  ? {30'h0, ovf_reg, ready_reg} :
    (wb_adr_i == ADR_COMM)   ? {31'h0, comm_reg} :
    (wb_adr_i == ADR_OC_LIM) ? {16'h0, oc_lim_reg} :
    (wb_adr_i == ADR_OP_LIM) ? {16'h0, op_lim_reg} :
    (wb_adr_i == ADR_UV_LIM) ? {16'h0, uv_lim_reg} :
    (wb_adr_i == ADR_OV_LIM) ? {16'h0, ov_lim_reg} :
    (wb_adr_i == ADR_WARN)   ? {28'h0, warn_reg} :
    (wb_adr_i == ADR_SHUNT)  ? {16'h0, res_sh_reg} :
    (wb_adr_i == ADR_BUS)    ? {16'h0, res_bu_reg} :
    (wb_adr_i == ADR_CURR)   ? {16'h0, res_cu_reg} :
    (wb_adr_i == ADR_POWER)  ? {16'h0, res_pw_reg} :
    (wb_adr_i == ADR_STATE)  ? {29'h0, alert_in, state_reg == ST_WAKE, asleep_reg} :
    32'h0000_0000;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ack_reg   <= 1'b0;
      dat_reg   <= 32'h0000_0000;
      alert_reg <= 1'b0;
    end else begin
      ack_reg   <= req && !ack_reg;
      dat_reg   <= (req && !ack_reg) ? rd_data : dat_reg;
      alert_reg <= alert_next;
    end
  end
  assign wb_ack_o  = ack_reg;
  assign wb_dat_o  = dat_reg;
  assign alert_oe  = alert_reg;
  assign alert_out = 1'b0;

  // assertions
  property p_alert;
    @(posedge sys_clk) disable iff (srst) (|(src_vec & mask_reg)) |=> alert_oe;
  endproperty
  a_alert: assert property (p_alert) else $error("alert not driven for enabled source");
  property p_release;
    @(posedge sys_clk) disable iff (srst) ((src_vec & mask_reg) == 7'h00) |=> !alert_oe;
  endproperty
  a_release: assert property (p_release) else $error("alert held with no active source");
  property p_comm;
    @(posedge sys_clk) disable iff (srst) comm_fault |=> comm_reg;
  endproperty
  a_comm: assert property (p_comm) else $error("communication fault lost");
  property p_ready;
    @(posedge sys_clk) disable iff (srst) upd |=> ready_reg && res_sh_reg == $past(avg_sh);
  endproperty
  a_ready: assert property (p_ready) else $error("ready or result missing after update");
  property p_ready_clr;
    @(posedge sys_clk) disable iff (srst) (wr_act || rd_mask) && !upd |=> !ready_reg;
  endproperty
  a_ready_clr: assert property (p_ready_clr) else $error("ready not cleared");
  property p_hold;
    @(posedge sys_clk) disable iff (srst) !$stable(res_cu_reg) |-> $past(state_reg) == ST_UPDATE;
  endproperty
  a_hold: assert property (p_hold) else $error("output changed outside update");
  property p_single;
    @(posedge sys_clk) disable iff (srst) upd && !cont && !wr_setup |=> state_reg == ST_IDLE ##1 !cv.start;
  endproperty
  a_single: assert property (p_single) else $error("triggered mode ran more than one set");
  property p_pd;
    @(posedge sys_clk) disable iff (srst) state_reg == ST_IDLE && !wr_act |=> state_reg == ST_IDLE && !cv.start;
  endproperty
  a_pd: assert property (p_pd) else $error("converter left idle without active write");
  property p_wake;
    @(posedge sys_clk) disable iff (srst) wr_act && asleep_reg ##1 !wr_setup [*8] |-> state_reg == ST_WAKE;
  endproperty
  a_wake: assert property (p_wake) else $error("no recovery wait after power-down");
  property p_power;
    @(posedge sys_clk) disable iff (srst) bu_done |=> pw_reg == $past(prod[30:15]) && state_reg == ST_ACC;
  endproperty
  a_power: assert property (p_power) else $error("power not taken after bus reading");
  c_update: cover property (@(posedge sys_clk) disable iff (srst) upd);
  c_alert:  cover property (@(posedge sys_clk) disable iff (srst) $rose(alert_oe));
  c_wake:   cover property (@(posedge sys_clk) disable iff (srst) state_reg == ST_WAKE ##1 state_reg == ST_LAUNCH);
endmodule // mas_top

// [src/mas_pkg.sv]
// shared constants, field layout and types of the monitor converter sequencer
package mas_pkg;
  localparam int CLK_PERIOD_NS   = 40;
  localparam int CLK_KHZ         = 1000000 / CLK_PERIOD_NS;
  localparam int MOD_RATE_KHZ    = 500;
  localparam int TICK_CYCLES_DEF = CLK_KHZ / MOD_RATE_KHZ;
  localparam int RECOVER_NS      = 40000;
  localparam int RECOVER_CYCLES  = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CT_US [8]       = '{140, 204, 332, 588, 1100, 2116, 4156, 8244};
  // register byte offsets
  localparam logic [7:0] ADR_SETUP  = 8'h00;
  localparam logic [7:0] ADR_MASK   = 8'h04;
  localparam logic [7:0] ADR_VSTAT  = 8'h08;
  localparam logic [7:0] ADR_COMM   = 8'h0C;
  localparam logic [7:0] ADR_OC_LIM = 8'h10;
  localparam logic [7:0] ADR_OP_LIM = 8'h14;
  localparam logic [7:0] ADR_UV_LIM = 8'h18;
  localparam logic [7:0] ADR_OV_LIM = 8'h1C;
  localparam logic [7:0] ADR_WARN   = 8'h20;
  localparam logic [7:0] ADR_SHUNT  = 8'h24;
  localparam logic [7:0] ADR_BUS    = 8'h28;
  localparam logic [7:0] ADR_CURR   = 8'h2C;
  localparam logic [7:0] ADR_POWER  = 8'h30;
  localparam logic [7:0] ADR_STATE  = 8'h34;
  // converter_setup fields
  localparam int MODE_LSB = 0;
  localparam int SCT_LSB  = 3;
  localparam int BCT_LSB  = 6;
  localparam int AVG_LSB  = 9;
  localparam logic [11:0] SETUP_RST = 12'h127;
  // alert_source_mask bits
  localparam int SRC_OC   = 0;
  localparam int SRC_OP   = 1;
  localparam int SRC_UV   = 2;
  localparam int SRC_OV   = 3;
  localparam int SRC_COMM = 4;
  localparam int SRC_OVF  = 5;
  localparam int SRC_RDY  = 6;
  localparam logic [6:0]  MASK_RST   = 7'h3F;
  localparam logic [15:0] HI_LIM_RST = 16'h7FF0;
  localparam logic [15:0] LO_LIM_RST = 16'h8000;
  localparam logic [15:0] FS_POS     = 16'h7FFF;
  localparam logic [15:0] FS_NEG     = 16'h8000;

  typedef enum logic [2:0] {ST_IDLE, ST_WAKE, ST_LAUNCH, ST_SHUNT, ST_BUS, ST_ACC, ST_UPDATE} mas_state_type;

  function automatic logic [12:0] mas_ct_ticks(input logic [2:0] code);
    mas_ct_ticks = 13'(CT_US[code] * MOD_RATE_KHZ / 1000);
  endfunction

  function automatic logic [3:0] mas_avg_shift(input logic [2:0] code);
    logic [3:0] s;
    s = 4'h0;
    unique case (code)
      3'h0: s = 4'h0;
      3'h1: s = 4'h2;
      3'h2: s = 4'h4;
      3'h3: s = 4'h6;
      3'h4: s = 4'h7;
      3'h5: s = 4'h8;
      3'h6: s = 4'h9;
      3'h7: s = 4'hA;
    endcase
    mas_avg_shift = s;
  endfunction
endpackage

// [src/mas_conv_if.sv]
// handshake between the sequencer and the conversion period timer
`timescale 1ns/1ns
interface mas_conv_if;
  logic       start;
  logic [2:0] ct_code;
  logic       done;
  modport seq (output start, output ct_code, input done);
  modport tmr (input start, input ct_code, output done);
endinterface

// [src/mas_conv_timer.sv]
// conversion period timer counting modulator ticks
`timescale 1ns/1ns
module mas_conv_timer
  import mas_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // sequencer side
  mas_conv_if.tmr  cv
);
  logic [15:0] pre_reg;
  logic [12:0] tick_reg;
  logic [2:0]  code_reg;
  logic        run_reg;
  logic        done_reg;
  wire         tick_w = run_reg && (pre_reg == 16'(TICK_CYCLES - 1));
  wire         last_w = tick_w && (tick_reg == mas_ct_ticks(code_reg) - 13'h1);

  always_ff @(posedge sys_clk) begin
    if (srst || cv.start) begin
      pre_reg  <= 16'h0000;
      tick_reg <= 13'h0000;
    end else if (tick_w) begin
      pre_reg  <= 16'h0000;
      tick_reg <= tick_reg + 13'h1;
    end else if (run_reg) begin
      pre_reg  <= pre_reg + 16'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      run_reg  <= 1'b0;
      done_reg <= 1'b0;
      code_reg <= 3'h0;
    end else begin
      run_reg  <= cv.start || (run_reg && !last_w);
      done_reg <= !cv.start && last_w;
      if (cv.start) begin
        code_reg <= cv.ct_code;
      end
    end
  end

  assign cv.done = done_reg;
endmodule // mas_conv_timer

// [verif/mas_alert_host.sv]
// host-side model of the open-drain alert wire with its pull-up
`timescale 1ns/1ns
module mas_alert_host (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // device alert driver
  input  wire logic       alert_out,
  input  wire logic       alert_oe,
  // wire level and alert event count
  output logic            alert_pin,
  output logic      [7:0] alert_cnt
);
  logic pin_q;

  // the pull-up holds the wire high whenever the device lets go
  assign alert_pin = alert_oe ? alert_out : 1'b1;

  // each falling edge is one alert the host has to service
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pin_q     <= 1'b1;
      alert_cnt <= 8'h00;
    end else begin
      pin_q <= alert_pin;
      if (pin_q && !alert_pin) begin
        alert_cnt <= alert_cnt + 8'h01;
      end
    end
  end
endmodule // mas_alert_host

// [verif/tb_top.sv]
// self-checking bench for the converter sequencer and alert logic
`timescale 1ns/1ns
module tb_top;
  import mas_pkg::*;
  localparam int TB_TICK = 1;
  logic        sys_clk, srst, wb_cyc, wb_stb, wb_we, comm_fault;
  logic        wb_ack_o, alert_out, alert_oe, alert_pin;
  logic [7:0]  wb_adr, alert_cnt;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat, wb_dat_o, rd;
  logic [15:0] shunt_sample, bus_sample;
  logic [31:0] cfg [2];
  int          failures, num_checks, cycle, n;
  int          exp_n [2];

  mas_top #(.TICK_CYCLES(TB_TICK)) i_mas_top (
    .sys_clk(sys_clk), .srst(srst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .shunt_sample(shunt_sample), .bus_sample(bus_sample), .comm_fault(comm_fault),
    .alert_in(alert_pin), .alert_out(alert_out), .alert_oe(alert_oe));
  mas_alert_host i_mas_alert_host (
    .sys_clk(sys_clk), .srst(srst), .alert_out(alert_out), .alert_oe(alert_oe),
    .alert_pin(alert_pin), .alert_cnt(alert_cnt));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cycle <= cycle + 1;

  task automatic give_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic fail(input string m);
    failures++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  // one classic cycle: hold everything until ack is sampled high
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, input logic [3:0] sel);
    int k;
    k = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_dat <= wd;
    wb_sel <= sel;
    do begin
      @(posedge sys_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20) fail("no bus answer");
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    xfer(1'b1, adr, d, 4'hF);
  endtask
  task automatic chk(input logic [7:0] adr, input logic [31:0] exp);
    xfer(1'b0, adr, 32'h0, 4'hF);
    num_checks++;
    if (rd !== exp) fail($sformatf("adr %h got %h want %h", adr, rd, exp));
  endtask
  task automatic pin(input logic exp);
    num_checks++;
    if (alert_pin !== exp) fail("alert pin level");
  endtask
  // polls the status word and returns the cycles spent
  task automatic wait_ready(output int el);
    int s;
    s = cycle;
    do xfer(1'b0, ADR_VSTAT, 32'h0, 4'hF);
    while (rd[0] !== 1'b1 && cycle - s < 12000);
    if (rd[0] !== 1'b1) fail("ready never set");
    el = cycle - s;
  endtask
  function automatic int span(input int s, input int b, input int nav);
    span = nav * (CT_US[s] * MOD_RATE_KHZ / 1000 * TB_TICK + CT_US[b] * MOD_RATE_KHZ / 1000 * TB_TICK + 5) + 1;
  endfunction

  initial begin
    repeat (40000) @(posedge sys_clk);
    fail("watchdog expired");
    give_verdict;
  end

  initial begin
    srst = 1'b1;
    {wb_cyc, wb_stb, wb_we, comm_fault} = 4'h0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat = 32'h0;
    shunt_sample = 16'h0100;
    bus_sample = 16'h0200;
    cycle = 0;
    failures = 0;
    num_checks = 0;
    cfg = '{32'h207, 32'h01B};
    exp_n = '{span(0, 0, 4), span(3, 0, 1)};
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    chk(ADR_SETUP, 32'h127);
    chk(ADR_MASK, 32'h3F);
    chk(ADR_OC_LIM, 32'h7FF0);
    chk(ADR_UV_LIM, 32'h8000);
    chk(8'h3C, 32'h0);
    xfer(1'b1, ADR_SETUP, 32'h003, 4'hC);
    chk(ADR_SETUP, 32'h127);
    // one triggered set of both channels
    wr(ADR_SETUP, 32'h003);
    wait_ready(n);
    chk(ADR_VSTAT, 32'h1);
    chk(ADR_SHUNT, 32'h0100);
    chk(ADR_BUS, 32'h0200);
    chk(ADR_CURR, 32'h0100);
    chk(ADR_POWER, 32'h0004);
    shunt_sample <= 16'h0300;
    bus_sample <= 16'h0400;
    repeat (600) @(posedge sys_clk);
    chk(ADR_SHUNT, 32'h0100);
    wr(ADR_SETUP, 32'h003);
    chk(ADR_VSTAT, 32'h0);
    wait_ready(n);
    chk(ADR_POWER, 32'h0018);
    // power-down keeps ready and register access
    wr(ADR_SETUP, 32'h000);
    chk(ADR_VSTAT, 32'h1);
    chk(ADR_STATE, 32'h5);
    wr(ADR_UV_LIM, 32'h1230);
    chk(ADR_UV_LIM, 32'h1230);
    wr(ADR_UV_LIM, 32'h8000);
    repeat (300) @(posedge sys_clk);
    chk(ADR_STATE, 32'h5);
    wr(ADR_SETUP, 32'h003);
    chk(ADR_STATE, 32'h6);
    repeat (900) @(posedge sys_clk);
    chk(ADR_VSTAT, 32'h0);
    wait_ready(n);
    chk(ADR_MASK, 32'h3F);
    chk(ADR_VSTAT, 32'h0);
    // update interval for averaging and split conversion times
    for (int i = 0; i < 2; i++) begin
      wr(ADR_SETUP, cfg[i]);
      wait_ready(n);
      num_checks++;
      if (n < exp_n[i] - 6 || n > exp_n[i] + 10) fail("update interval");
    end
    // single-channel modes, continuous shunt then triggered bus
    shunt_sample <= 16'h0500;
    bus_sample <= 16'h0600;
    wr(ADR_SETUP, 32'h005);
    wait_ready(n);
    chk(ADR_SHUNT, 32'h0500);
    chk(ADR_BUS, 32'h0400);
    chk(ADR_CURR, 32'h0500);
    wr(ADR_SETUP, 32'h002);
    wait_ready(n);
    chk(ADR_BUS, 32'h0600);
    chk(ADR_SHUNT, 32'h0500);
    chk(ADR_POWER, 32'h003C);
    // overflow and overcurrent share the alert pin
    wr(ADR_MASK, 32'h21);
    wr(ADR_OC_LIM, 32'h0100);
    shunt_sample <= 16'h7FFF;
    bus_sample <= 16'h0200;
    wr(ADR_SETUP, 32'h003);
    wait_ready(n);
    chk(ADR_VSTAT, 32'h3);
    chk(ADR_WARN, 32'h1);
    pin(1'b0);
    chk(ADR_STATE, 32'h0);
    chk(ADR_MASK, 32'h21);
    wr(ADR_VSTAT, 32'h2);
    repeat (3) @(posedge sys_clk);
    pin(1'b0);
    wr(ADR_WARN, 32'h1);
    repeat (3) @(posedge sys_clk);
    pin(1'b1);
    chk(ADR_STATE, 32'h4);
    // serial fault pulse
    wr(ADR_MASK, 32'h10);
    comm_fault <= 1'b1;
    @(posedge sys_clk);
    comm_fault <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(ADR_COMM, 32'h1);
    pin(1'b0);
    wr(ADR_COMM, 32'h1);
    repeat (3) @(posedge sys_clk);
    pin(1'b1);
    num_checks++;
    if (alert_cnt !== 8'h02) fail("alert event count");
    give_verdict;
  end
endmodule // tb_top
